// ---- verilog/accel_config_and_sample_readout.sv ----
// How it works
// - writing zero to main control enters stand-by unless the rate code is in the full-power span; no conversions then run.
// - code 0x40 keeps stand-by below the full-power rates and picks 12-bit resolution at 2g range.
// - 14-bit resolution is given only when the 8g range is selected.
// - rate code two means 50 Hz and is the rate register reset value.
// - rates of 400 Hz or more force operate-enable and resolution select on.
// - setting operate-enable with the config bits starts operating mode and sampling.
// - samples are two's complement, width fixed by resolution at operating entry.
// - 12-bit: bits 11..4 in high byte, bits 3..0 in low upper nibble.
// - 14-bit: bits 13..6 in high byte, bits 5..0 in low bits 7..2.
// - 8-bit: whole sample in high byte, low byte don't-care.
// - X low/high, then Y low/high, then Z low at consecutive offsets.
`timescale 1ns/1ns
`default_nettype none
module accel_config_and_sample_readout
  import accel_regs_pkg::*;
#(
  parameter int sample_width = raw_sample_width
)
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  input wire logic sample_valid,
  input wire logic [sample_width-1:0] x_sample_in,
  input wire logic [sample_width-1:0] y_sample_in,
  input wire logic [sample_width-1:0] z_sample_in,
  output logic operating_q,
  output logic conversion_run_q,
  output logic [1:0] sample_mode_q
);
  if (sample_width != raw_sample_width) begin : g_width_check
    $error("sample_width must equal the 14-bit converter width");
  end
  if (axis_count != 3) begin : g_axis_check
    $error("axis_count must be 3 to match the x, y and z register map");
  end
  if (range_msb != range_lsb + 1) begin : g_range_check
    $error("the range field must be two bits wide");
  end
  if (rate_full_power_min > rate_full_power_max) begin : g_rate_check
    $error("full-power rate codes must form a rising span");
  end
  if (output_sample_rate_msb - output_sample_rate_lsb != 3) begin : g_rate_field_check
    $error("the rate code field must be four bits wide");
  end
  if ((operate_enable_bit > 7) || (resolution_select_bit > 7) || (range_msb > 7)) begin : g_bit_check
    $error("control fields must sit inside the 8-bit main control register");
  end
  if ((x_sample_high_addr != x_sample_low_addr + 8'h01)
      || (y_sample_low_addr != x_sample_low_addr + 8'h02)) begin : g_map_check
    $error("axis sample offsets must be consecutive low and high pairs");
  end

  // stored configuration and derived settings
  logic [7:0] main_control_q;
  logic [7:0] sample_rate_control_q;
  sample_mode_t mode_q;
  sample_mode_t mode_d;
  logic [3:0] rate_code;
  logic force_full_power;
  logic operate_eff;
  logic resolution_eff;
  logic [1:0] range_sel;
  logic [7:0] lo_byte [axis_count];
  logic [7:0] hi_byte [axis_count];
  logic [7:0] lo_q [axis_count];
  logic [7:0] hi_q [axis_count];
  logic [sample_width-1:0] raw_in [axis_count];
  // decoded strobes and read selection
  logic wr_main;
  logic wr_rate;
  logic sample_take;
  logic enter_operating;
  logic [7:0] rdata_d;

  // converter inputs by axis index
  assign raw_in[0] = x_sample_in;
  assign raw_in[1] = y_sample_in;
  assign raw_in[2] = z_sample_in;

  // effective settings
  assign rate_code = sample_rate_control_q[output_sample_rate_msb:output_sample_rate_lsb];

  // rate codes in the full-power span stand for 400 Hz and above
  always_comb begin
    force_full_power = 1'b0;
    if ((rate_code >= rate_full_power_min) && (rate_code <= rate_full_power_max)) begin
      force_full_power = 1'b1;
    end
  end

  assign operate_eff = main_control_q[operate_enable_bit] | force_full_power;
  assign resolution_eff = main_control_q[resolution_select_bit] | force_full_power;
  assign range_sel = main_control_q[range_msb:range_lsb];

  // write strobes and capture enable
  assign wr_main = reg_wr && (reg_addr == main_control_addr);
  assign wr_rate = reg_wr && (reg_addr == sample_rate_control_addr);
  assign sample_take = operating_q && sample_valid;
  assign enter_operating = operate_eff && !operating_q;

  // resolution picked from the effective settings; 14-bit only at 8g
  always_comb begin
    mode_d = mode_8bit;
    if (resolution_eff) begin
      if (range_sel == range_8g) begin
        mode_d = mode_14bit;
      end else begin
        mode_d = mode_12bit;
      end
    end
  end

  // main control register, stored as written
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      main_control_q <= main_control_rst;
    end else if (wr_main) begin
      main_control_q <= reg_wdata;
    end
  end

  // rate control register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sample_rate_control_q <= sample_rate_control_rst;
    end else if (wr_rate) begin
      sample_rate_control_q <= reg_wdata;
    end
  end

  // operating state follows the effective operate-enable
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      operating_q <= 1'b0;
    end else begin
      operating_q <= operate_eff;
    end
  end

  // resolution frozen on entry so a late write cannot reshape samples
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_q <= mode_8bit;
    end else if (enter_operating) begin
      mode_q <= mode_d;
    end
  end

  // one pulse per accepted sample
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      conversion_run_q <= 1'b0;
    end else begin
      conversion_run_q <= sample_take;
    end
  end

  // mode reported straight from its register
  assign sample_mode_q = mode_q;

  // per-axis formatting and holding
  for (genvar a = 0; a < axis_count; a++) begin : g_axis
    axis_byte_packer u_packer (
      .mode(mode_q),
      .raw_sample(raw_in[a]),
      .low_byte(lo_byte[a]),
      .high_byte(hi_byte[a])
    );
    // low byte of this axis
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        lo_q[a] <= 8'h00;
      end else if (sample_take) begin
        lo_q[a] <= lo_byte[a];
      end
    end
    // high byte of this axis
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        hi_q[a] <= 8'h00;
      end else if (sample_take) begin
        hi_q[a] <= hi_byte[a];
      end
    end
  end

  // read data selection; sample offsets form low then high pairs for X and Y, then Z low only
  always_comb begin
    rdata_d = unmapped_rdata;
    case (reg_addr)
      x_sample_low_addr: rdata_d = lo_q[0];
      x_sample_high_addr: rdata_d = hi_q[0];
      y_sample_low_addr: rdata_d = lo_q[1];
      y_sample_high_addr: rdata_d = hi_q[1];
      z_sample_low_addr: rdata_d = lo_q[2];
      main_control_addr: rdata_d = main_control_q;
      sample_rate_control_addr: rdata_d = sample_rate_control_q;
      default: rdata_d = unmapped_rdata;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata_q <= unmapped_rdata;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // read answer valid one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
    end
  end
endmodule
`default_nettype wire

// ---- inc/accel_regs_pkg.sv ----
package accel_regs_pkg;
  // register offsets
  localparam logic [7:0] x_sample_low_addr = 8'h06;
  localparam logic [7:0] x_sample_high_addr = 8'h07;
  localparam logic [7:0] y_sample_low_addr = 8'h08;
  localparam logic [7:0] y_sample_high_addr = 8'h09;
  localparam logic [7:0] z_sample_low_addr = 8'h0a;
  localparam logic [7:0] main_control_addr = 8'h1b;
  localparam logic [7:0] sample_rate_control_addr = 8'h21;
  // reset values
  localparam logic [7:0] main_control_rst = 8'h00;
  localparam logic [7:0] sample_rate_control_rst = 8'h02;
  localparam logic [7:0] unmapped_rdata = 8'h00;
  // main control fields
  localparam int operate_enable_bit = 7;
  localparam int resolution_select_bit = 6;
  localparam int range_lsb = 3;
  localparam int range_msb = 4;
  localparam logic [1:0] range_2g = 2'h0;
  localparam logic [1:0] range_8g = 2'h2;
  // rate control field
  localparam int output_sample_rate_lsb = 0;
  localparam int output_sample_rate_msb = 3;
  localparam logic [3:0] rate_50hz = 4'h2;
  localparam logic [3:0] rate_full_power_min = 4'h5;
  localparam logic [3:0] rate_full_power_max = 4'h7;
  // sample width and axis count
  localparam int raw_sample_width = 14;
  localparam int axis_count = 3;
  typedef enum logic [1:0] {
    mode_8bit,
    mode_12bit,
    mode_14bit
  } sample_mode_t;
endpackage

// ---- verilog/axis_byte_packer.sv ----
`timescale 1ns/1ns
`default_nettype none
module axis_byte_packer
  import accel_regs_pkg::*;
(
  input wire sample_mode_t mode,
  input wire logic [raw_sample_width-1:0] raw_sample,
  output logic [7:0] low_byte,
  output logic [7:0] high_byte
);
  // dropping the low bits keeps the two's complement sign
  always_comb begin
    case (mode)
      mode_14bit: begin
        high_byte = raw_sample[13:6];
        low_byte = {raw_sample[5:0], 2'h0};
      end
      mode_12bit: begin
        high_byte = raw_sample[13:6];
        low_byte = {raw_sample[5:2], 4'h0};
      end
      default: begin
        high_byte = raw_sample[13:6];
        low_byte = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- tb/acc_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module acc_chk
  import accel_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic reg_rvalid_q,
  input wire logic sample_valid,
  input wire logic operating_q,
  input wire logic conversion_run_q,
  input wire logic [1:0] sample_mode_q
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_read_answer: assert property (
    reg_rd |=> reg_rvalid_q) else $error("read answer missing");
  a_answer_cause: assert property (
    reg_rvalid_q |-> $past(reg_rd)) else $error("read answer without read");
  a_enable_operates: assert property (
    reg_wr && reg_addr == main_control_addr && reg_wdata[operate_enable_bit] |-> ##2 operating_q)
    else $error("operate enable ignored");
  a_rate_forces: assert property (
    reg_wr && reg_addr == sample_rate_control_addr && reg_wdata[3:0] >= rate_full_power_min
    && reg_wdata[3:0] <= rate_full_power_max |-> ##2 operating_q) else $error("no full power");
  a_run_follows: assert property (
    sample_valid && operating_q |=> conversion_run_q) else $error("sample not taken");
  a_run_cause: assert property (
    conversion_run_q |-> $past(sample_valid && operating_q)) else $error("stray conversion");
  a_mode_held: assert property (
    operating_q && $past(operating_q) |-> $stable(sample_mode_q)) else $error("mode moved");
  a_mode_entry: assert property (
    $rose(operating_q)
    && $past(reg_wr && reg_addr == main_control_addr && reg_wdata[resolution_select_bit], 2)
    |-> sample_mode_q == ($past(reg_wdata[range_msb:range_lsb], 2) == range_8g ? 2'h2 : 2'h1))
    else $error("wrong mode on entry");
endmodule
bind accel_config_and_sample_readout acc_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid_q(reg_rvalid_q),
  .sample_valid(sample_valid), .operating_q(operating_q),
  .conversion_run_q(conversion_run_q), .sample_mode_q(sample_mode_q));
`default_nettype wire

// ---- tb/acc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module acc_host (
  input wire logic clk_sys,
  output logic [7:0] reg_addr = 8'h00,
  output logic reg_wr = 1'b0,
  output logic [7:0] reg_wdata = 8'h00,
  output logic reg_rd = 1'b0
);
  // settings only in stand-by, operate enable last
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys) #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(posedge clk_sys) #1;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys) #1;
    reg_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_accel_config_and_sample_readout.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_accel_config_and_sample_readout
  import accel_regs_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sample_valid = 1'b0;
  logic [13:0] smp = 14'h0000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic reg_wr, reg_rd, reg_rvalid_q, operating_q, crun;
  logic [1:0] smode;
  int err_total = 0;
  int n_compared = 0;
  always #5 clk_sys = ~clk_sys;
  acc_host u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  accel_config_and_sample_readout u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .sample_valid(sample_valid),
    .x_sample_in(smp), .y_sample_in(~smp), .z_sample_in(smp), .operating_q(operating_q),
    .conversion_run_q(crun), .sample_mode_q(smode));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g,
    input logic [7:0] m);
    n_compared++;
    if ((g & m) !== (e & m)) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e & m, g & m);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e,
    input logic [7:0] m);
    u_host.rd(a);
    chk(n, e, reg_rdata_q, m);
    chk("rvalid", 8'h01, {7'h0, reg_rvalid_q}, 8'hff);
    @(posedge clk_sys) #1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_mode(input logic [7:0] cfg, input logic [13:0] raw, input logic [7:0] m,
    input logic [1:0] em);
    logic [13:0] v;
    u_host.wr(main_control_addr, 8'h00);
    u_host.wr(main_control_addr, cfg);
    chk("standby", 8'h00, {7'h0, operating_q}, 8'hff);
    u_host.wr(main_control_addr, cfg | 8'h80);
    chk("operating", 8'h01, {7'h0, operating_q}, 8'hff);
    chk("mode", {6'h0, em}, {6'h0, smode}, 8'hff);
    smp = raw;
    sample_valid = 1'b1;
    @(posedge clk_sys) #1;
    sample_valid = 1'b0;
    chk("run", 8'h01, {7'h0, crun}, 8'hff);
    for (int i = 0; i < 5; i++) begin
      v = (i / 2 == 1) ? ~raw : raw;
      rchk("sample", 8'h06 + 8'(i), i % 2 ? v[13:6] : {v[5:0], 2'h0}, i % 2 ? 8'hff : m);
    end
  endtask
  task automatic t_rate;
    u_host.wr(main_control_addr, 8'h00);
    smp = 14'h1234;
    sample_valid = 1'b1;
    @(posedge clk_sys) #1;
    sample_valid = 1'b0;
    chk("idle run", 8'h00, {7'h0, crun}, 8'hff);
    rchk("held", x_sample_high_addr, 8'h3e, 8'hff);
    u_host.wr(sample_rate_control_addr, {4'h0, rate_full_power_min});
    chk("forced", 8'h01, {7'h0, operating_q}, 8'hff);
    chk("forced mode", 8'h01, {6'h0, smode}, 8'hff);
    rchk("main_control", main_control_addr, 8'h00, 8'hff);
    u_host.wr(sample_rate_control_addr, {4'h0, rate_50hz});
    chk("released", 8'h00, {7'h0, operating_q}, 8'hff);
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    rchk("main_control", main_control_addr, 8'h00, 8'hff);
    rchk("rate", sample_rate_control_addr, 8'h02, 8'hff);
    rchk("unmapped", 8'h0b, 8'h00, 8'hff);
    t_mode(8'h40, 14'h2a5c, 8'hf0, 2'h1);
    t_mode(8'h50, 14'h3123, 8'hfc, 2'h2);
    t_mode(8'h48, 14'h1e37, 8'hf0, 2'h1);
    t_mode(8'h10, 14'h0f81, 8'h00, 2'h0);
    t_rate;
    tally_and_finish;
  end
endmodule
`default_nettype wire
